// [design/sar_avg_pkg.sv]
// Notes on behaviour
// - Reset logic at power-up or supply loss
// - Convert-start rising edge starts a conversion
// - Start requests ignored while converting
// - Busy high exactly while converting
// - Power down and acquire after conversion
// - Conversion completes within 675ns
// - Result readable while powered down
// - Keep 24-bit result of latest conversion
// - Filter loads averages into output register
// - Output follows result when read every cycle
// - Twenty SCKs give valid 20-bit result
// - Accumulate until read; read resets filter
// - Average 1 to 65536 results, no setup
// - All accumulated results weighted equally
// - Divide by next power of two
// - 1 to 19 SCKs keep output register
// - 0 or 20+ SCKs reload output register
// - Divisor stays 65536 beyond that count
package sar_avg_pkg;

  // Widths of the datapath
  localparam int DATA_W = 24;
  localparam int ACC_W = 40;
  localparam int CNT_W = 17;
  localparam int EDGE_W = 8;
  localparam int SHIFT_W = 5;
  localparam int CONV_CNT_W = 5;

  // Timing: reference clock period and longest conversion time
  localparam int CLK_PERIOD_NS = 25;
  localparam int CONV_TIME_NS = 675;
  // Longest time rounds down to whole cycles
  localparam int CONV_CYCLES = CONV_TIME_NS / CLK_PERIOD_NS;

  // Read protocol and filter limits
  localparam logic [EDGE_W-1:0] MIN_READ_EDGES = 8'h14;
  localparam int MAX_SHIFT = 16;
  localparam logic [CNT_W-1:0] MAX_COUNT = 17'h1FFFF;
  localparam logic [DATA_W-1:0] FULL_SCALE = 24'hFFFFFF;
  localparam logic [ACC_W-1:0] ACC_MAX = 40'hFFFFFFFFFF;

  // Conversion phase, one-hot
  typedef enum logic [1:0] {
    CONV_ACQUIRE = 2'b01,
    CONV_RUN = 2'b10
  } conv_phase_type;

  // What the link side needs from the reference side (quasi-static)
  typedef struct packed {
    logic [DATA_W-1:0] ioData;
    logic [EDGE_W-1:0] readBase;
  } link_view_type;

  // Whole state of the reference-clock side
  typedef struct packed {
    conv_phase_type phase;
    logic [CONV_CNT_W-1:0] convCnt;
    logic startMeta;
    logic startSync;
    logic startPrev;
    logic supplyMeta;
    logic supplySync;
    logic [EDGE_W-1:0] grayMeta;
    logic [EDGE_W-1:0] graySync;
    logic [EDGE_W-1:0] cycleBase;
    logic [DATA_W-1:0] convResult;
    logic [ACC_W-1:0] acc;
    logic [CNT_W-1:0] avgCount;
    logic readActive;
    logic busy;
    logic powered;
    link_view_type view;
  } main_state_type;

  // Whole state of the serial-clock side
  typedef struct packed {
    logic [EDGE_W-1:0] edgeCnt;
    logic [EDGE_W-1:0] edgeGray;
    logic sdo;
  } link_state_type;

  // Reset values
  localparam main_state_type MAIN_RESET = '{phase: CONV_ACQUIRE, default: '0};
  localparam link_state_type LINK_RESET = '{default: '0};

  // Binary to gray code
  function automatic logic [EDGE_W-1:0] bin_to_gray(input logic [EDGE_W-1:0] b);
    return b ^ (b >> 1);
  endfunction

  // Gray code to binary
  function automatic logic [EDGE_W-1:0] gray_to_bin(input logic [EDGE_W-1:0] g);
    logic [EDGE_W-1:0] b;
    b = '0;
    b[EDGE_W-1] = g[EDGE_W-1];
    for (int i = EDGE_W - 2; i >= 0; i--) begin
      b[i] = g[i] ^ b[i+1];
    end
    return b;
  endfunction

  // Shift giving the next power of two at or above the count, capped at 16
  function automatic logic [SHIFT_W-1:0] avg_shift(input logic [CNT_W-1:0] count);
    logic [SHIFT_W-1:0] sh;
    sh = '0;
    for (int i = 0; i < MAX_SHIFT; i++) begin
      if (count > (CNT_W'(1) << i)) begin
        sh = SHIFT_W'(i + 1);
      end
    end
    return sh;
  endfunction

  // Scaled average, clipped at full scale
  function automatic logic [DATA_W-1:0] avg_value(input logic [ACC_W-1:0] acc,
                                                   input logic [CNT_W-1:0] count);
    logic [ACC_W-1:0] q;
    q = acc >> avg_shift(count);
    return (|q[ACC_W-1:DATA_W]) ? FULL_SCALE : q[DATA_W-1:0];
  endfunction

endpackage

// [design/sar_sck_shifter.sv]
`timescale 1ns/1ps
`default_nettype none
// Serial side: runs on the host's SCK, counts edges and shifts the output word
module sar_sck_shifter
  import sar_avg_pkg::*;
(
  input wire logic sck,
  input wire logic rst_n,
  input wire link_view_type view,
  output logic [EDGE_W-1:0] edgeGray,
  output logic sdo
);

  link_state_type s; // Current state
  link_state_type next_s; // Next state
  logic [EDGE_W-1:0] bitIdx; // Bit position inside the current read

  // Next state on each rising SCK edge
  always_comb begin
    next_s = s;
    bitIdx = s.edgeCnt - view.readBase;
    next_s.edgeCnt = s.edgeCnt + 8'h01;
    next_s.edgeGray = bin_to_gray(next_s.edgeCnt);
    if (bitIdx < EDGE_W'(DATA_W)) begin
      next_s.sdo = view.ioData[5'(DATA_W - 1) - bitIdx[4:0]];
    end else begin
      // Past the last bit the line rests low
      next_s.sdo = 1'b0;
    end
  end

  // State register on the link clock
  always_ff @(posedge sck or negedge rst_n) begin
    if (!rst_n) begin
      s <= LINK_RESET;
    end else begin
      s <= next_s;
    end
  end

  assign edgeGray = s.edgeGray;
  assign sdo = s.sdo;

  // First edge of a read always presents the MSB
  property p_msb_first;
    @(posedge sck) disable iff (!rst_n)
      (s.edgeCnt == view.readBase) |=> (sdo == $past(view.ioData[DATA_W-1]));
  endproperty
  a_msb_first: assert property (p_msb_first) else $error("first bit is not MSB");

  // Gray counter moves by one bit per edge
  property p_gray_step;
    @(posedge sck) disable iff (!rst_n)
      1'b1 |=> $countones(edgeGray ^ $past(edgeGray)) == 1;
  endproperty
  a_gray_step: assert property (p_gray_step) else $error("gray count skipped");

endmodule
`default_nettype wire

// [design/sar_adc_averaging_readout.sv]
`timescale 1ns/1ps
`default_nettype none
// Conversion control, averaging filter and output register of the converter
module sar_adc_averaging_readout
  import sar_avg_pkg::*;
#(
  parameter int CONV_CYCLES_P = CONV_CYCLES
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic sck,
  input wire logic convert_start,
  input wire logic supplyLow,
  input wire logic [DATA_W-1:0] coreResult,
  output logic busy,
  output logic corePowered,
  output logic sdo
);

  // Last count value of a conversion
  localparam logic [CONV_CNT_W-1:0] CONV_LAST = CONV_CNT_W'(CONV_CYCLES_P - 1);
  // Cycles after its rise for which busy must still stand
  localparam int BUSY_HOLD = CONV_CYCLES_P - 1;

  main_state_type s; // Current state
  main_state_type next_s; // Next state
  logic [EDGE_W-1:0] linkGray; // Edge count from the link side, gray coded
  logic [EDGE_W-1:0] edgeNow; // Edge count seen here, binary
  logic [EDGE_W-1:0] cycleEdges; // Edges since last conversion end
  logic startEdge; // Rising convert_start, synchronised
  logic convDone; // Last cycle of a conversion
  logic readStart; // First SCK edge of a new read seen
  logic readEnd; // This conversion end closes the read
  logic [ACC_W:0] accSum; // Accumulator plus new result, with carry
  logic [DATA_W-1:0] avgNext; // Average that would load now

  // The output word and bit base reach the serial side as a quasi-static
  // pair: they move only at a conversion end or on supply loss, while the host keeps SCK
  // still, so no handshake is needed on that path. Edge counts travel the
  // other way in gray code through two flops, so a count caught mid-change
  // is off by at most one edge and is put right on the next cycle.
  // Serial clock domain: edge counting and shifting
  sar_sck_shifter u_shifter (
    .sck(sck),
    .rst_n(rst_n),
    .view(s.view),
    .edgeGray(linkGray),
    .sdo(sdo)
  );

  // Next state of the reference side
  always_comb begin
    next_s = s;
    accSum = '0;
    avgNext = '0;
    readEnd = 1'b0;
    convDone = 1'b0;
    // Two-flop synchronisers for pins and the link counter
    next_s.startMeta = convert_start;
    next_s.startSync = s.startMeta;
    next_s.startPrev = s.startSync;
    next_s.supplyMeta = supplyLow;
    next_s.supplySync = s.supplyMeta;
    next_s.grayMeta = linkGray;
    next_s.graySync = s.grayMeta;
    // Edge detect on the synchronised start pin
    startEdge = s.startSync & ~s.startPrev;
    // Serial edges seen so far, back in binary
    edgeNow = gray_to_bin(s.graySync);
    // Edges given since the last conversion end
    cycleEdges = edgeNow - s.cycleBase;
    // First edge while no read is open begins one
    readStart = ~s.readActive & (cycleEdges != '0);

    // Conversion sequencing
    unique case (s.phase)
      CONV_ACQUIRE: begin
        if (startEdge) begin
          next_s.phase = CONV_RUN;
          next_s.convCnt = '0;
          next_s.busy = 1'b1;
          next_s.powered = 1'b1;
        end
      end
      CONV_RUN: begin
        if (s.convCnt == CONV_LAST) begin
          convDone = 1'b1;
          next_s.phase = CONV_ACQUIRE;
          next_s.busy = 1'b0;
          next_s.powered = 1'b0;
        end else begin
          next_s.convCnt = s.convCnt + 5'h01;
        end
      end
    endcase

    if (readStart) begin
      next_s.acc = '0;
      next_s.avgCount = '0;
      next_s.readActive = 1'b1;
    end

    if (convDone) begin
      next_s.convResult = coreResult;
      accSum = {1'b0, next_s.acc} + {17'h00000, coreResult};
      next_s.acc = accSum[ACC_W] ? ACC_MAX : accSum[ACC_W-1:0];
      if (next_s.avgCount != MAX_COUNT) begin
        next_s.avgCount = next_s.avgCount + 17'h00001;
      end
      avgNext = avg_value(next_s.acc, next_s.avgCount);
      // zero or 20+ edges end read
      readEnd = (cycleEdges == '0) || (cycleEdges >= MIN_READ_EDGES);
      // 1 to 19 edges hold output
      if (readEnd) begin
        // single result when read each cycle
        next_s.view.ioData = avgNext;
        // Next read counts its bits from here
        next_s.view.readBase = edgeNow;
        next_s.readActive = 1'b0;
      end
      // Edges of the next cycle count from here
      next_s.cycleBase = edgeNow;
    end

    // Overrides the conversion, filter, read and output updates above in the same cycle
    // supply loss reinitialises
    if (s.supplySync) begin
      next_s.phase = CONV_ACQUIRE;
      next_s.convCnt = '0;
      next_s.busy = 1'b0;
      next_s.powered = 1'b0;
      next_s.convResult = '0;
      next_s.acc = '0;
      next_s.avgCount = '0;
      next_s.readActive = 1'b0;
      next_s.cycleBase = edgeNow;
      next_s.view.ioData = '0;
      next_s.view.readBase = edgeNow;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      s <= MAIN_RESET;
    end else begin
      s <= next_s;
    end
  end

  // Status outputs straight from their state flops
  assign busy = s.busy;
  assign corePowered = s.powered;

  // Busy stands for the whole conversion, then drops
  property p_busy_length;
    @(posedge ref_clk) disable iff (!rst_n || s.supplySync)
      $rose(busy) |-> (busy throughout ##BUSY_HOLD 1'b1) ##1 !busy;
  endproperty
  a_busy_length: assert property (p_busy_length) else $error("busy length wrong");

  // A start edge while idle raises busy and power next cycle
  property p_start;
    @(posedge ref_clk) disable iff (!rst_n || s.supplySync)
      (startEdge && s.phase == CONV_ACQUIRE) |=> (busy && corePowered);
  endproperty
  a_start: assert property (p_start) else $error("start edge not taken");

  // Start edges during a conversion do not restart the count
  property p_no_restart;
    @(posedge ref_clk) disable iff (!rst_n || s.supplySync)
      (s.phase == CONV_RUN && s.convCnt != CONV_LAST) |=>
        (s.convCnt == $past(s.convCnt) + 5'h01);
  endproperty
  a_no_restart: assert property (p_no_restart) else $error("conversion restarted");

  // Power drops together with busy
  property p_power_down;
    @(posedge ref_clk) disable iff (!rst_n)
      $fell(busy) |-> !corePowered;
  endproperty
  a_power_down: assert property (p_power_down) else $error("no power-down");

  // Result register catches the core word at conversion end
  property p_capture;
    @(posedge ref_clk) disable iff (!rst_n || s.supplySync)
      convDone |=> (s.convResult == $past(coreResult));
  endproperty
  a_capture: assert property (p_capture) else $error("result not captured");

  // Short edge bursts keep the output register
  property p_hold;
    @(posedge ref_clk) disable iff (!rst_n || s.supplySync)
      (convDone && !readEnd) |=> $stable(s.view.ioData);
  endproperty
  a_hold: assert property (p_hold) else $error("output changed mid read");

  // A closing conversion end loads the new average
  property p_reload;
    @(posedge ref_clk) disable iff (!rst_n || s.supplySync)
      (convDone && readEnd) |=> (s.view.ioData == $past(avgNext));
  endproperty
  a_reload: assert property (p_reload) else $error("output not reloaded");

  // A read start empties the filter
  property p_filter_reset;
    @(posedge ref_clk) disable iff (!rst_n || s.supplySync)
      (readStart && !convDone) |=> (s.acc == '0 && s.avgCount == '0 && s.readActive);
  endproperty
  a_filter_reset: assert property (p_filter_reset) else $error("filter not reset");

  // Three results are divided by four
  property p_scale;
    @(posedge ref_clk) disable iff (!rst_n)
      (s.avgCount == 17'h00003) |-> (avg_value(s.acc, s.avgCount) == s.acc[25:2]);
  endproperty
  a_scale: assert property (p_scale) else $error("scale wrong");

  // Synchronised supply loss clears the converter on the next cycle
  property p_supply;
    @(posedge ref_clk) disable iff (!rst_n)
      s.supplySync |=> (!busy && s.acc == '0);
  endproperty
  a_supply: assert property (p_supply) else $error("supply loss ignored");

  // Converter power follows busy exactly
  property p_power_follows;
    @(posedge ref_clk) disable iff (!rst_n)
      busy == corePowered;
  endproperty
  a_power_follows: assert property (p_power_follows) else $error("power not busy");

  // Busy stands exactly while the phase is running
  property p_phase_busy;
    @(posedge ref_clk) disable iff (!rst_n)
      busy == (s.phase == CONV_RUN);
  endproperty
  a_phase_busy: assert property (p_phase_busy) else $error("busy off phase");

  // Conversion count never passes its last value
  property p_conv_bound;
    @(posedge ref_clk) disable iff (!rst_n)
      s.convCnt <= CONV_LAST;
  endproperty
  a_conv_bound: assert property (p_conv_bound) else $error("conversion too long");

  // Each completed result adds in with unit weight
  property p_acc_add;
    @(posedge ref_clk) disable iff (!rst_n || s.supplySync)
      (convDone && !readStart && !accSum[ACC_W]) |=>
        (s.acc == $past(s.acc) + ACC_W'($past(coreResult)));
  endproperty
  a_acc_add: assert property (p_acc_add) else $error("result not summed");

  // Each completed result counts once, with no setup
  property p_count_step;
    @(posedge ref_clk) disable iff (!rst_n || s.supplySync)
      (convDone && !readStart && s.avgCount != MAX_COUNT) |=>
        (s.avgCount == $past(s.avgCount) + 17'h00001);
  endproperty
  a_count_step: assert property (p_count_step) else $error("count not stepped");

  // A reloading conversion end closes the open read
  property p_read_close;
    @(posedge ref_clk) disable iff (!rst_n || s.supplySync)
      (convDone && readEnd) |=> !s.readActive;
  endproperty
  a_read_close: assert property (p_read_close) else $error("read left open");

  // Output register moves only at a conversion end or on supply loss
  property p_output_quiet;
    @(posedge ref_clk) disable iff (!rst_n || s.supplySync)
      !convDone |=> $stable(s.view);
  endproperty
  a_output_quiet: assert property (p_output_quiet) else $error("output moved early");

  // Supply loss empties the output word and closes any read
  property p_supply_link;
    @(posedge ref_clk) disable iff (!rst_n)
      s.supplySync |=> (s.view.ioData == '0 && !s.readActive);
  endproperty
  a_supply_link: assert property (p_supply_link) else $error("output kept on loss");

  // Main scenarios
  c_conversion: cover property (@(posedge ref_clk) disable iff (!rst_n) $fell(busy));
  c_reload: cover property (@(posedge ref_clk) disable iff (!rst_n) convDone && readEnd);
  c_distributed: cover property (@(posedge ref_clk) disable iff (!rst_n) convDone && !readEnd);
  c_average4: cover property (@(posedge ref_clk) disable iff (!rst_n)
    convDone && readEnd && s.avgCount == 17'h00003);
  c_twenty: cover property (@(posedge ref_clk) disable iff (!rst_n)
    convDone && cycleEdges == MIN_READ_EDGES);

endmodule
`default_nettype wire

// [verification/sar_host_model.sv]
`timescale 1ns/1ps
`default_nettype none
// Host side: starts conversions and clocks results out on its own serial clock
module sar_host_model
  import sar_avg_pkg::*;
(
  input wire logic ref_clk,
  input wire logic busy,
  input wire logic sdo,
  output var logic convert_start,
  output var logic sck
);
  // Half period of the serial clock, 64 ns period
  localparam real SCK_HALF = 32.0;

  // Idle levels at time zero
  initial begin
    convert_start = 1'b0;
    sck = 1'b0;
  end

  // Clock n bits out MSB first, sampling on the falling edge
  task automatic read(input int n, output logic [DATA_W-1:0] word);
    word = '0;
    for (int i = 0; i < n; i++) begin
      #SCK_HALF sck = 1'b1;
      #SCK_HALF sck = 1'b0;
      word = {word[DATA_W-2:0], sdo};
    end
    #SCK_HALF;
  endtask

  // Wait out re-initialisation, then flush the serial registers
  task automatic powerUp();
    logic [DATA_W-1:0] dummy;
    repeat (8000) @(posedge ref_clk);
    read(20, dummy);
  endtask

  // One conversion; reports how many cycles busy stood high
  task automatic convert(input logic glitch, output int busyCycles);
    int waited;
    busyCycles = 0;
    waited = 0;
    repeat (13) @(posedge ref_clk);
    #1 convert_start = 1'b1;
    while (busy !== 1'b1 && waited < 20) begin
      @(posedge ref_clk);
      #1;
      waited++;
    end
    while (busy === 1'b1 && busyCycles < 60) begin
      busyCycles++;
      // Refusal case: a second start edge mid-conversion
      if (glitch && busyCycles == 10) convert_start = 1'b0;
      if (glitch && busyCycles == 12) convert_start = 1'b1;
      @(posedge ref_clk);
      #1;
    end
    convert_start = 1'b0;
    // Keep serial edges clear of the busy fall
    repeat (4) @(posedge ref_clk);
  endtask
endmodule
`default_nettype wire

// [verification/sar_adc_averaging_readout_tb.sv]
`timescale 1ns/1ps
`default_nettype none
// Self-checking bench for conversion control and averaging readout
module sar_adc_averaging_readout_tb
  import sar_avg_pkg::*;
;
  logic refClk;
  logic rstN;
  logic supplyLow;
  logic [DATA_W-1:0] coreResult;
  wire sck;
  wire convertStart;
  wire busy;
  wire corePowered;
  wire sdo;
  // Mismatch and comparison counters
  int nMismatch;
  int checkCount;
  // Scratch for counts and words
  int busyCycles;
  logic [DATA_W-1:0] word;
  logic [DATA_W-1:0] part;
  logic [DATA_W+1:0] sum;

  sar_adc_averaging_readout sar_adc_averaging_readout_inst (
    .ref_clk(refClk), .rst_n(rstN), .sck(sck), .convert_start(convertStart),
    .supplyLow(supplyLow), .coreResult(coreResult), .busy(busy),
    .corePowered(corePowered), .sdo(sdo)
  );

  sar_host_model sar_host_model_inst (
    .ref_clk(refClk), .busy(busy), .sdo(sdo), .convert_start(convertStart), .sck(sck)
  );

  // Reference clock, 25 ns
  initial begin
    refClk = 1'b0;
    forever #12.5 refClk = ~refClk;
  end

  // Compare and count
  task automatic compare(input logic [DATA_W-1:0] got, exp, input string what);
    checkCount++;
    if (got !== exp) begin
      nMismatch++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // Verdict and end of run
  task automatic results();
    if (nMismatch == 0 && checkCount > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // Convert one value and check how long busy stood
  task automatic conv(input logic [DATA_W-1:0] value, input logic glitch);
    @(posedge refClk);
    #1 coreResult = value;
    fork
      sar_host_model_inst.convert(glitch, busyCycles);
      begin
        // Converter must be powered while busy stands
        @(posedge busy);
        #1 compare({23'h000000, corePowered}, 24'h000001, "powered during");
      end
    join
    compare(DATA_W'(busyCycles), DATA_W'(CONV_CYCLES), "busy length");
    compare({23'h000000, corePowered}, 24'h000000, "powered after");
  endtask

  // Full 24-bit read against an expected word
  task automatic readFull(input logic [DATA_W-1:0] exp, input string what);
    sar_host_model_inst.read(24, word);
    compare(word, exp, what);
  endtask

  // Outputs quiet during reset
  task automatic testReset();
    compare({22'h000000, busy, corePowered}, 24'h000000, "reset outputs");
    compare({23'h000000, sdo}, 24'h000000, "reset sdo");
  endtask

  // Read every result: output tracks single conversions
  task automatic testConventional();
    conv(24'hA5C3F1, 1'b0);
    readFull(24'hA5C3F1, "single result");
    conv(24'h123456, 1'b1);
    repeat (10) @(posedge refClk);
    compare({23'h000000, busy}, 24'h000000, "restart ignored");
    readFull(24'h123456, "after refused start");
  endtask

  // Three unread conversions averaged over the next power of two
  task automatic testAverage3();
    conv(24'hFFFFF0, 1'b0);
    conv(24'h800001, 1'b0);
    conv(24'h00ABCD, 1'b0);
    sum = 26'(24'h800001) + 26'(24'h00ABCD) + 26'(24'hFFFFF0);
    readFull(sum[DATA_W+1:2], "average of three");
  endtask

  // Twenty clocks give the top twenty bits, and close the read
  task automatic test20Bit();
    conv(24'h3C5A96, 1'b0);
    sar_host_model_inst.read(20, word);
    compare({4'h0, word[19:0]}, {4'h0, 20'h3C5A9}, "twenty bit read");
    conv(24'hC0FFEE, 1'b0);
    readFull(24'hC0FFEE, "reload after twenty");
  endtask

  // Eight bits per cycle hold the word; an empty cycle reloads
  task automatic testDistributed();
    conv(24'h5AA5C3, 1'b0);
    sar_host_model_inst.read(8, part);
    word[23:16] = part[7:0];
    conv(24'h000010, 1'b0);
    sar_host_model_inst.read(8, part);
    word[15:8] = part[7:0];
    conv(24'h000020, 1'b0);
    sar_host_model_inst.read(8, part);
    word[7:0] = part[7:0];
    compare(word, 24'h5AA5C3, "distributed read");
    conv(24'h000030, 1'b0);
    conv(24'h000044, 1'b0);
    readFull(24'h000029, "average of four");
  endtask

  // Supply loss mid-conversion stops it; operation resumes afterwards
  task automatic testSupplyLoss();
    fork
      sar_host_model_inst.convert(1'b0, busyCycles);
      begin
        repeat (30) @(posedge refClk);
        #1 supplyLow = 1'b1;
      end
    join
    compare(DATA_W'(busyCycles < CONV_CYCLES), 24'h000001, "conversion cut");
    compare({22'h000000, busy, corePowered}, 24'h000000, "idle in re-init");
    repeat (8) @(posedge refClk);
    #1 supplyLow = 1'b0;
    sar_host_model_inst.powerUp();
    conv(24'h777777, 1'b0);
    sar_host_model_inst.read(24, word);
    conv(24'h0F0F0F, 1'b0);
    readFull(24'h0F0F0F, "after re-init");
  endtask

  // Watchdog cuts a hang short
  initial begin
    #1000000;
    nMismatch++;
    results();
  end

  // Main sequence
  initial begin
    nMismatch = 0;
    checkCount = 0;
    rstN = 1'b0;
    supplyLow = 1'b0;
    coreResult = '0;
    repeat (16) @(posedge refClk);
    testReset();
    #1 rstN = 1'b1;
    sar_host_model_inst.powerUp();
    testConventional();
    testAverage3();
    test20Bit();
    testDistributed();
    testSupplyLoss();
    results();
  end
endmodule
`default_nettype wire
